// >>> src/stack_guard_pkg.sv
// Package holding register map, field layout, reset values and carriers of the stack guard.
package stack_guard_pkg;
   // ==========================================================
   // Register offsets (byte addresses on the register bus).
   localparam logic [7:0] OFS_PTR_LOW = 8'h81;
   localparam logic [7:0] OFS_PTR_HIGH = 8'hB7;
   localparam logic [7:0] OFS_LIMIT_CTRL = 8'hBF;
   localparam logic [7:0] OFS_CORE_STATUS = 8'hC0;
   // ==========================================================
   // Field positions.
   localparam int HIGH_RSVD_BIT = 7;
   localparam int HIGH_SBFLAG_BIT = 6;
   localparam int HIGH_START_MSB = 5;
   localparam int HIGH_START_LSB = 3;
   localparam int HIGH_PTR_MSB = 2;
   localparam int CTRL_WATER_MSB = 7;
   localparam int CTRL_WATER_LSB = 3;
   localparam int CTRL_RESP_BIT = 2;
   localparam int CTRL_ENABLE_BIT = 1;
   localparam int CTRL_WFLAG_BIT = 0;
   // ==========================================================
   // Reset values and address constants.
   localparam logic [10:0] PTR_RESET = 11'h100;
   localparam logic [2:0] START_RESET = 3'h1;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [10:0] RAM_TOP = 11'h7FF;
   localparam int RAM_DEPTH = 2048;
   // ==========================================================
   // Core stack request carried as one packed word.
   typedef struct packed {
      logic push;
      logic pop;
      logic [7:0] data;
   } stack_req_t;
   // Violation response to the core.
   typedef struct packed {
      logic irq;
      logic reset;
      logic water_cause;
      logic bottom_cause;
   } violation_t;
   typedef enum logic [1:0] {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage : stack_guard_pkg

// >>> src/stack_guard.sv
// Extended stack pointer with waterline and stack-bottom protection behind Wishbone.
//
// Contract
// - push increments pointer then writes byte.
// - pop reads top byte then decrements.
// - address is high bits 2:0 plus low byte.
// - pointer and start reset to 0x100.
// - start bits set start address msbs.
// - overflow past top wraps to start address.
// - protection off at reset; enable bit arms.
// - waterline is 0x7FF minus waterline field.
// - zero waterline field disables waterline monitor.
// - pointer write below start suppressed, violation.
// - reset response resets part immediately.
// - interrupt response uses watchdog vector, needs enable.
// - protection off means no interrupt or reset.
// - waterline flag clears only below waterline.
// - external reset pin clears waterline flag.
// - bottom flag survives internal resets until cleared.
// - lowering start with pointer flags bottom violation.
// - response bit zero gives interrupt.
`timescale 1ns/1ps
`default_nettype none
module stack_guard
   import stack_guard_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ext_rst_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [7:0] wb_dat_i,
   output logic [7:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire stack_req_t core_req_i,
   output logic [7:0] pop_data_o,
   output logic pop_valid_o,
   output logic [10:0] stack_addr_o,
   output violation_t violation_o,
   input wire logic high_irq_active_i
);
   // ==========================================================
   // State.
   logic [10:0] ptr_reg, ptr_next;
   logic [2:0] start_reg, start_next;
   logic rsvd_reg, rsvd_next;
   logic sbflag_reg, sbflag_next;
   logic [7:0] ctrl_reg, ctrl_next;
   logic wflag_reg, wflag_next;
   logic [7:0] ram_reg [RAM_DEPTH];
   logic [7:0] rdat_reg, pop_data_reg;
   logic pop_valid_reg;
   violation_t viol_reg, viol_next;
   bus_state_t bus_reg;
   // ==========================================================
   // Decode of the bus and field views.
   // A request is answered from idle, but a write only lands at the edge that samples ack.
   // Landing it one edge earlier would let a master that never waits for ack alter state.
   wire bus_req = wb_cyc_i && wb_stb_i && (bus_reg == BUS_IDLE);
   wire bus_commit = wb_cyc_i && wb_stb_i && (bus_reg == BUS_ACK);
   wire bus_wr = bus_commit && wb_we_i && wb_sel_i;
   wire wr_low = bus_wr && (wb_adr_i == OFS_PTR_LOW);
   wire wr_high = bus_wr && (wb_adr_i == OFS_PTR_HIGH);
   wire wr_ctrl = bus_wr && (wb_adr_i == OFS_LIMIT_CTRL);
   wire [4:0] water_field = ctrl_reg[CTRL_WATER_MSB:CTRL_WATER_LSB];
   wire protect_on = ctrl_reg[CTRL_ENABLE_BIT];
   wire resp_reset = ctrl_reg[CTRL_RESP_BIT];
   wire [10:0] waterline = RAM_TOP - {6'h00, water_field};
   wire [10:0] start_addr = {start_reg, 8'h00};
   // ==========================================================
   // Candidate pointer from the core or a register write.
   wire [10:0] push_ptr = (ptr_reg == RAM_TOP) ? start_addr : ptr_reg + 11'h001;
   wire [10:0] pop_ptr = ptr_reg - 11'h001;
   wire [2:0] wr_start = wb_dat_i[HIGH_START_MSB:HIGH_START_LSB];
   wire [10:0] wr_ptr_low = {ptr_reg[10:8], wb_dat_i};
   wire [10:0] wr_ptr_high = {wb_dat_i[HIGH_PTR_MSB:0], ptr_reg[7:0]};
   wire [10:0] new_start = wr_high ? {wr_start, 8'h00} : start_addr;
   // A write landing below the current or newly written start is the bottom breach.
   wire low_below = wr_low && (wr_ptr_low < start_addr);
   wire high_below = wr_high && (wr_ptr_high < new_start);
   wire start_lowered = wr_high && (wr_start < start_reg)
      && (wb_dat_i[HIGH_PTR_MSB:0] != ptr_reg[10:8]);
   wire pop_below = core_req_i.pop && (pop_ptr < start_addr);
   wire bottom_hit = protect_on && (low_below || high_below || start_lowered
      || pop_below);
   // Waterline watch on the pointer that is about to be taken.
   wire [10:0] cand_ptr = core_req_i.push ? push_ptr : ptr_reg;
   wire water_hit = protect_on && (water_field != 5'h00) && core_req_i.push
      && (cand_ptr >= waterline);
   wire sw_clear_wflag = wr_ctrl && !wb_dat_i[CTRL_WFLAG_BIT] && (ptr_reg < waterline);
   // ==========================================================
   // Next-state logic for pointer, control and flags.
   always_comb begin
      ptr_next = ptr_reg;
      start_next = start_reg;
      rsvd_next = rsvd_reg;
      sbflag_next = sbflag_reg;
      ctrl_next = ctrl_reg;
      wflag_next = wflag_reg;
      if (core_req_i.push) begin
         ptr_next = push_ptr;
      end else if (core_req_i.pop && !bottom_hit) begin
         ptr_next = pop_ptr;
      end else if (wr_low && !bottom_hit) begin
         ptr_next = wr_ptr_low;
      end else if (wr_high && !bottom_hit) begin
         ptr_next = wr_ptr_high;
      end
      if (wr_high && !bottom_hit) begin
         start_next = wr_start;
         rsvd_next = wb_dat_i[HIGH_RSVD_BIT];
      end
      // Software may only clear the flag; the hardware set wins.
      if (wr_high && !wb_dat_i[HIGH_SBFLAG_BIT]) begin
         sbflag_next = 1'b0;
      end
      if (bottom_hit) begin
         sbflag_next = 1'b1;
      end
      if (wr_ctrl) begin
         ctrl_next = {wb_dat_i[7:1], 1'b0};
      end
      if (sw_clear_wflag) begin
         wflag_next = 1'b0;
      end
      if (water_hit) begin
         wflag_next = 1'b1;
      end
   end
   // Response selection; nothing fires while protection is off.
   always_comb begin
      viol_next = '0;
      viol_next.water_cause = water_hit;
      viol_next.bottom_cause = bottom_hit;
      if (water_hit || bottom_hit) begin
         viol_next.reset = resp_reset;
         viol_next.irq = !resp_reset && !high_irq_active_i;
      end
   end
   // ==========================================================
   // Register update. Flags survive rst_i; ext_rst_i clears both the waterline and bottom flags.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ptr_reg <= PTR_RESET;
         start_reg <= START_RESET;
         rsvd_reg <= 1'b1;
         ctrl_reg <= CTRL_RESET;
         viol_reg <= '0;
      end else begin
         ptr_reg <= ptr_next;
         start_reg <= start_next;
         rsvd_reg <= rsvd_next;
         ctrl_reg <= ctrl_next;
         viol_reg <= viol_next;
      end
   end
   always_ff @(posedge clk_i) begin
      if (ext_rst_i) begin
         wflag_reg <= 1'b0;
         sbflag_reg <= 1'b0;
      end else begin
         wflag_reg <= wflag_next;
         sbflag_reg <= sbflag_next;
      end
   end
   // ==========================================================
   // Extended RAM; a push writes at the incremented address.
   always_ff @(posedge clk_i) begin
      if (core_req_i.push) begin
         ram_reg[push_ptr] <= core_req_i.data;
      end
   end
   // Pop data comes from the current top before the decrement.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pop_data_reg <= 8'h00;
         pop_valid_reg <= 1'b0;
      end else begin
         pop_valid_reg <= core_req_i.pop;
         if (core_req_i.pop) begin
            pop_data_reg <= ram_reg[ptr_reg];
         end
      end
   end
   // ==========================================================
   // Wishbone slave: registered acknowledge one cycle after the request, then one idle cycle.
   wire [7:0] high_view = {rsvd_reg, sbflag_reg, start_reg, ptr_reg[10:8]};
   wire [7:0] ctrl_view = {ctrl_reg[7:1], wflag_reg};
   wire [7:0] rd_mux = (wb_adr_i == OFS_PTR_LOW) ? ptr_reg[7:0] :
      (wb_adr_i == OFS_PTR_HIGH) ? high_view :
      (wb_adr_i == OFS_LIMIT_CTRL) ? ctrl_view :
      (wb_adr_i == OFS_CORE_STATUS) ? {4'h0, viol_reg} : 8'h00;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_reg <= BUS_IDLE;
         rdat_reg <= 8'h00;
      end else begin
         case (bus_reg)
            BUS_IDLE: begin
               if (bus_req) begin
                  bus_reg <= BUS_ACK;
                  rdat_reg <= rd_mux;
               end
            end
            BUS_ACK: bus_reg <= BUS_IDLE;
            default: bus_reg <= BUS_IDLE;
         endcase
      end
   end
   assign wb_ack_o = (bus_reg == BUS_ACK);
   assign wb_dat_o = rdat_reg;
   assign pop_data_o = pop_data_reg;
   assign pop_valid_o = pop_valid_reg;
   assign stack_addr_o = ptr_reg;
   assign violation_o = viol_reg;
   // ==========================================================
   // Checks.
   a_push_incr: assert property (@(posedge clk_i) disable iff (rst_i)
      core_req_i.push && ptr_reg != RAM_TOP |=> ptr_reg == $past(ptr_reg) + 11'h001)
      else $error("push did not increment pointer");
   a_wrap_start: assert property (@(posedge clk_i) disable iff (rst_i)
      core_req_i.push && ptr_reg == RAM_TOP |=> ptr_reg == {$past(start_reg), 8'h00})
      else $error("overflow did not wrap to start");
   a_off_silent: assert property (@(posedge clk_i) disable iff (rst_i)
      !protect_on |=> !violation_o.irq && !violation_o.reset)
      else $error("violation raised while protection off");
   a_bottom_block: assert property (@(posedge clk_i) disable iff (rst_i)
      protect_on && low_below && !core_req_i.push && !core_req_i.pop |=> $stable(ptr_reg))
      else $error("write below start not suppressed");
   a_bottom_flag: assert property (@(posedge clk_i) disable iff (rst_i || ext_rst_i)
      bottom_hit |=> sbflag_reg && violation_o.bottom_cause)
      else $error("bottom flag not set");
   a_reset_resp: assert property (@(posedge clk_i) disable iff (rst_i)
      (water_hit || bottom_hit) && resp_reset |=> violation_o.reset && !violation_o.irq)
      else $error("reset response missing");
   a_irq_resp: assert property (@(posedge clk_i) disable iff (rst_i)
      (water_hit || bottom_hit) && !resp_reset && !high_irq_active_i |=> violation_o.irq)
      else $error("interrupt response missing");
   a_water_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      water_field == 5'h00 |=> !violation_o.water_cause)
      else $error("waterline fired with zero field");
   a_wflag_hold: assert property (@(posedge clk_i) disable iff (rst_i || ext_rst_i)
      wflag_reg && ptr_reg >= waterline |=> wflag_reg)
      else $error("waterline flag cleared above waterline");
   a_pop_decr: assert property (@(posedge clk_i) disable iff (rst_i)
      core_req_i.pop && !core_req_i.push && !bottom_hit |=> ptr_reg == $past(ptr_reg) - 11'h001)
      else $error("pop did not decrement pointer");
   a_water_set: assert property (@(posedge clk_i) disable iff (rst_i || ext_rst_i)
      water_hit |=> wflag_reg && violation_o.water_cause)
      else $error("waterline flag not set");
   a_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
      (water_hit || bottom_hit) && high_irq_active_i |=> !violation_o.irq)
      else $error("interrupt raised during higher service");
   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge held longer than one cycle");
endmodule : stack_guard
`default_nettype wire

// >>> bench/core_model.sv
// Behavioural processor core that issues stack pushes and pops.
`timescale 1ns/1ps
`default_nettype none
module core_model
   import stack_guard_pkg::*;
(
   input wire logic clk_i,
   output stack_req_t req_o,
   output logic hi_irq_o
);
   // ==========================================================
   // One request per call; the strobe drops at the edge that takes it.
   initial begin
      req_o = '0;
      hi_irq_o = 1'b0;
   end
   task automatic op(input logic psh, input logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{push: psh, pop: !psh, data: d};
      @(posedge clk_i);
      req_o <= '0;
   endtask : op
endmodule : core_model
`default_nettype wire

// >>> bench/test_stack_guard.sv
// Self-checking bench for the stack guard: bus registers, stack ops, violations.
`timescale 1ns/1ps
`default_nettype none
module test_stack_guard;
   import stack_guard_pkg::*;
   logic clk = 1'b0, rst = 1'b1, xrst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [7:0] adr = 8'h00, dat = 8'h00, rdat, pdat, d0, d1;
   logic pval;
   logic [10:0] saddr;
   stack_req_t req;
   violation_t vio;
   logic hi;
   int err_count = 0, num_checks = 0, cycles = 0, n_irq = 0, n_rst = 0, snap;
   logic [7:0] q_rd[$], q_pop[$];
   always #10 clk = ~clk;
   stack_guard u_dut (.clk_i(clk), .rst_i(rst), .ext_rst_i(xrst), .wb_adr_i(adr),
      .wb_dat_i(dat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_ack_o(ack), .core_req_i(req), .pop_data_o(pdat),
      .pop_valid_o(pval), .stack_addr_o(saddr), .violation_o(vio), .high_irq_active_i(hi));
   core_model u_core (.clk_i(clk), .req_o(req), .hi_irq_o(hi));
   // ==========================================================
   // Comparison, verdict and hang guard.
   task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   // Monitor: results are matched to the oldest note as they appear.
   // Outputs launch on the rising edge, so they are looked at on the falling edge.
   always @(negedge clk) begin
      cycles++;
      if (cycles > 4000) begin
         err_count++;
         tally_and_finish();
      end
      if (ack && !we) check("read data", {3'h0, rdat}, {3'h0, q_rd.pop_front()});
      if (pval) check("pop data", {3'h0, pdat}, {3'h0, q_pop.pop_front()});
      if (vio.irq) n_irq++;
      if (vio.reset) n_rst++;
   end
   // ==========================================================
   // Classic single-cycle bus master; a read notes its expected value.
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      if (!w) q_rd.push_back(d);
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 1'b0; stb <= 1'b0;
   endtask : bus
   task automatic addr_is(input logic [10:0] e);
      @(posedge clk);
      check("stack address", saddr, e);
   endtask : addr_is
   // ==========================================================
   // Main sequence; high writes keep the reserved bit set.
   initial begin
      void'($urandom(94547));
      d0 = 8'($urandom()); d1 = 8'($urandom());
      repeat (8) @(posedge clk);
      rst <= 1'b0; xrst <= 1'b0;
      bus(0, OFS_PTR_LOW, 8'h00); bus(0, OFS_PTR_HIGH, 8'h89);
      bus(0, OFS_LIMIT_CTRL, 8'h00); bus(0, 8'h90, 8'h00);
      $display("reset values done");
      u_core.op(1, d0); addr_is(11'h101);
      u_core.op(1, d1); addr_is(11'h102);
      q_pop.push_back(d1); q_pop.push_back(d0);
      u_core.op(0, 8'h00); u_core.op(0, 8'h00); addr_is(11'h100);
      $display("push pop done");
      bus(1, OFS_PTR_HIGH, 8'hB6); addr_is(11'h600);
      bus(1, OFS_PTR_LOW, 8'hFD); bus(1, OFS_PTR_HIGH, 8'hB7); addr_is(11'h7FD);
      bus(1, OFS_LIMIT_CTRL, 8'h0A);
      u_core.op(1, d0); addr_is(11'h7FE);
      bus(0, OFS_LIMIT_CTRL, 8'h0B);
      u_core.op(1, d1); u_core.op(1, d0); addr_is(11'h600);
      check("irq seen", 11'(n_irq != 0), 11'h1);
      check("reset unseen", 11'(n_rst), 11'h0);
      bus(1, OFS_LIMIT_CTRL, 8'h0A); bus(0, OFS_LIMIT_CTRL, 8'h0A);
      $display("waterline done");
      bus(1, OFS_PTR_HIGH, 8'hB5); addr_is(11'h600);
      bus(0, OFS_PTR_HIGH, 8'hF6);
      bus(1, OFS_LIMIT_CTRL, 8'h0E); bus(1, OFS_PTR_HIGH, 8'hF5); addr_is(11'h600);
      check("reset seen", 11'(n_rst != 0), 11'h1);
      $display("bottom done");
      snap = n_irq + n_rst;
      bus(1, OFS_LIMIT_CTRL, 8'h08); bus(1, OFS_PTR_HIGH, 8'hF5); addr_is(11'h500);
      u_core.op(1, d0); repeat (2) @(posedge clk);
      check("quiet when off", 11'(n_irq + n_rst - snap), 11'h0);
      @(posedge clk) xrst <= 1'b1;
      @(posedge clk) xrst <= 1'b0;
      bus(0, OFS_PTR_HIGH, 8'hB5); bus(0, OFS_LIMIT_CTRL, 8'h08);
      $display("disable and pin reset done");
      repeat (3) @(posedge clk);
      tally_and_finish();
   end
endmodule : test_stack_guard
`default_nettype wire
